// File: hw/readout_pkg.sv
/*
  Package for the sensor readout timing controller: field widths, reset
  values, timing constants, state encoding and the port carrier structs.
  Assumes a single master clock; all times are counted in its periods.
*/
package readout_pkg;

  // ==========================================================
  // widths and reset values
  localparam int unsigned ROW_W = 10;
  localparam int unsigned COL_W = 10;
  localparam int unsigned SH_W = 8;
  localparam int unsigned CNT_W = 24;
  localparam logic [COL_W-1:0] VCOL_RST = 10'h170; // 368 columns
  localparam logic [ROW_W-1:0] VROW_RST = 10'h1f3; // 499 rows
  localparam logic [ROW_W-1:0] CINT_RST = 10'h1f3; // 499 rows
  localparam logic [SH_W-1:0] SH_RST = 8'h00;

  // ==========================================================
  // timing counts, in master clock periods
  localparam logic [CNT_W-1:0] ROW_FIXED = 24'h000013; // 19 fixed periods per row
  localparam logic [CNT_W-1:0] CLAMP_LIM = 24'h00018f; // 399 periods
  localparam logic [CNT_W-1:0] CLAMP_OVH = 24'h000190; // 400 periods, >= limit
  localparam logic [CNT_W-1:0] SNAP_STEP = 24'h000010; // 16 periods per step

  // ==========================================================
  // field encodings
  localparam logic CAP_ROLLING = 1'b0;
  localparam logic CAP_SNAPSHOT = 1'b1;
  localparam logic SCAN_PROG = 1'b0;
  localparam logic SCAN_INTERLACE = 1'b1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_INTEG = 5'b00010,
    ST_XFER = 5'b00100,
    ST_ROW = 5'b01000,
    ST_CLAMP = 5'b10000
  } state_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic capture_mode; // 0 rolling, 1 snapshot
    logic scan_mode; // 0 progressive, 1 interlaced
    logic bayer_space; // subsample in 2x2 tiles
    logic [1:0] sub_h; // 0 full,1 half,2 quarter,3 eighth
    logic [1:0] sub_v;
    logic [ROW_W-1:0] win_row;
    logic [COL_W-1:0] win_col;
    logic [ROW_W-1:0] win_depth;
    logic [COL_W-1:0] win_width;
    logic [ROW_W-1:0] vrow_depth;
    logic [COL_W-1:0] vcol_width;
    logic [SH_W-1:0] shs;
    logic [SH_W-1:0] shr;
    logic [ROW_W-1:0] cint;
    logic [CNT_W-1:0] sint;
  } cfg_t;

  typedef struct packed {
    logic frame_valid;
    logic line_valid;
    logic pixel_valid;
    logic field_odd;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [7:0] pixel;
  } vid_t;

  typedef struct packed {
    logic row_reset; // row shutter reset (starts integration)
    logic [ROW_W-1:0] reset_row;
    logic global_reset; // snapshot: all rows reset together
    logic global_xfer; // snapshot: all pixels to floating diffusion
    logic clamp_active;
  } ctl_t;

endpackage

// File: hw/readout_timing.sv
/*
  Readout timing and sequencing controller for a colour image sensor.
  Walks a virtual frame column by column and row by row, tags positions
  inside the readout window and drives shutter controls for rolling or
  snapshot capture. Assumes configuration is static during a frame and
  that pixel samples arrive synchronous to clk_sys from the converter.
*/
// Notes on behaviour
// - reset selects rolling capture unless snapshot chosen
// - rolling: staggered row resets, equal integration
// - snapshot: global integrate, transfer, sequential readout
// - capture mode from capture mode field
// - interlaced: odd field then even field
// - progressive: every window row, one pass
// - scan mode from scan mode field
// - window by pointer, depth and width
// - independent h/v subsample, mono or bayer
// - frame time from rows, row time, clamp
// - row time is columns plus sh plus 19
// - clamp limit is 399 clock periods
// - long rows: integration is cint plus one rows
// - short rows: first rows add clamp overhead
// - snapshot integration is count times sixteen
// - reset values 368 columns, 499 rows
`timescale 1ns/1ps
module readout_timing
  import readout_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire cfg_t cfg,
  input wire logic cfg_load,
  input wire logic snap_start,
  input wire logic [7:0] adc_pixel,
  output vid_t vid,
  output ctl_t ctl,
  output logic [CNT_W-1:0] row_time,
  output logic busy
);

  // ==========================================================
  // state record
  typedef struct packed {
    state_t st;
    cfg_t cf;
    logic [CNT_W-1:0] cyc;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
    logic odd_pass;
    logic first_frame;
    vid_t v;
    ctl_t c;
  } regs_t;

  regs_t q, d;

  // reset register values for the config copy
  localparam cfg_t CFG_RST = '{
    capture_mode: CAP_ROLLING, scan_mode: SCAN_PROG, bayer_space: 1'b0,
    sub_h: 2'h0, sub_v: 2'h0, win_row: '0, win_col: '0,
    win_depth: 10'h120, win_width: 10'h160,
    vrow_depth: VROW_RST, vcol_width: VCOL_RST,
    shs: SH_RST, shr: SH_RST, cint: CINT_RST, sint: '0};

  // ==========================================================
  // derived timing
  logic [CNT_W-1:0] trow;
  logic short_row;
  logic [ROW_W-1:0] row_last;
  logic [ROW_W-1:0] reset_lead;
  logic in_win_r;
  logic in_win_c;
  logic keep_r;
  logic keep_c;
  logic [ROW_W-1:0] wr;
  logic [COL_W-1:0] wc;
  logic [CNT_W-1:0] snap_len;

  assign trow = CNT_W'(q.cf.vcol_width) + CNT_W'(q.cf.shs) + CNT_W'(q.cf.shr)
              + ROW_FIXED;
  assign short_row = (trow < CLAMP_LIM);
  assign row_last = q.cf.vrow_depth;
  // lead of row reset ahead of readout: cint+1 rows
  assign reset_lead = q.cf.cint + 10'h001;
  assign snap_len = CNT_W'(q.cf.sint * SNAP_STEP);

  assign wr = q.row - q.cf.win_row;
  assign wc = q.col - q.cf.win_col;

  assign in_win_r = (q.row >= q.cf.win_row) && (wr < q.cf.win_depth);
  assign in_win_c = (q.col >= q.cf.win_col) && (wc < q.cf.win_width);

  // subsample keep: bayer space keeps 2x2 tiles, mono single pixels
  always_comb begin
    logic [ROW_W-1:0] rsel;
    logic [COL_W-1:0] csel;
    rsel = q.cf.bayer_space ? (wr >> 1) : wr;
    csel = q.cf.bayer_space ? (wc >> 1) : wc;
    case (q.cf.sub_v)
      2'h0: keep_r = 1'b1;
      2'h1: keep_r = (rsel[0] == 1'b0);
      2'h2: keep_r = (rsel[1:0] == 2'h0);
      default: keep_r = (rsel[2:0] == 3'h0);
    endcase
    case (q.cf.sub_h)
      2'h0: keep_c = 1'b1;
      2'h1: keep_c = (csel[0] == 1'b0);
      2'h2: keep_c = (csel[1:0] == 2'h0);
      default: keep_c = (csel[2:0] == 3'h0);
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    logic row_end;
    logic [ROW_W-1:0] next_row;
    logic frame_end;
    d = q;
    d.c.row_reset = 1'b0;
    d.c.global_reset = 1'b0;
    d.c.global_xfer = 1'b0;
    d.v.pixel_valid = 1'b0;
    row_end = (CNT_W'(q.col) + 24'h000001 >= trow);
    // interlaced steps two rows; progressive steps one
    next_row = q.row + ((q.cf.scan_mode == SCAN_INTERLACE) ? 10'h002 : 10'h001);
    // virtual frame holds vrow_depth rows, indices 0..depth-1
    frame_end = (next_row >= row_last);
    case (q.st)
      ST_IDLE: begin
        if (cfg_load) begin
          d.cf = cfg;
        end
        // rolling runs free; snapshot waits for a start
        if (q.cf.capture_mode == CAP_ROLLING) begin
          d.st = ST_CLAMP;
          d.cyc = '0;
          d.row = '0;
          d.odd_pass = 1'b1;
        end else if (snap_start) begin
          d.c.global_reset = 1'b1;
          d.st = ST_INTEG;
          // count starts at one: the transfer cycle closes the interval
          d.cyc = 24'h000001;
        end
      end
      ST_INTEG: begin
        d.cyc = q.cyc + 24'h000001;
        if (q.cyc + 24'h000001 >= snap_len) begin
          d.st = ST_XFER;
        end
      end
      ST_XFER: begin
        // one-cycle transfer of all pixels at once
        d.c.global_xfer = 1'b1;
        d.st = ST_ROW;
        d.row = '0;
        d.col = '0;
        d.odd_pass = 1'b1;
        d.v.frame_valid = 1'b1;
      end
      ST_CLAMP: begin
        d.cyc = q.cyc + 24'h000001;
        // short rows: add fixed clamp overhead; else one row time
        if (q.cyc + 24'h000001 >= (short_row ? CLAMP_OVH : trow)) begin
          d.st = ST_ROW;
          d.col = '0;
          d.row = (q.cf.scan_mode == SCAN_INTERLACE && !q.odd_pass) ? 10'h001 : 10'h000;
          d.v.frame_valid = 1'b1;
          d.v.field_odd = q.odd_pass;
          // first rows integrate across the clamp overhead
          d.first_frame = 1'b0;
        end
      end
      ST_ROW: begin
        d.col = q.col + 10'h001;
        // window test gates pixel output; timing unchanged
        d.v.pixel_valid = in_win_r && in_win_c && keep_r && keep_c
                        && (CNT_W'(q.col) < CNT_W'(q.cf.vcol_width));
        d.v.line_valid = in_win_r && keep_r;
        d.v.row = wr;
        d.v.col = wc;
        d.v.pixel = adc_pixel;
        // rolling shutter: reset row ahead of readout by cint+1
        if (q.cf.capture_mode == CAP_ROLLING && q.col == '0) begin
          d.c.row_reset = 1'b1;
          d.c.reset_row = (q.row + reset_lead >= row_last)
                        ? q.row + reset_lead - row_last
                        : q.row + reset_lead;
        end
        if (row_end) begin
          d.col = '0;
          d.row = next_row;
          d.v.line_valid = 1'b0;
          if (frame_end) begin
            d.v.frame_valid = 1'b0;
            d.cyc = '0;
            if (q.cf.scan_mode == SCAN_INTERLACE && q.odd_pass) begin
              d.odd_pass = 1'b0;
              d.st = ST_CLAMP;
            end else if (q.cf.capture_mode == CAP_ROLLING) begin
              d.odd_pass = 1'b1;
              if (cfg_load) begin
                d.cf = cfg;
              end
              d.st = (cfg_load && cfg.capture_mode == CAP_SNAPSHOT) ? ST_IDLE : ST_CLAMP;
            end else begin
              d.st = ST_IDLE;
            end
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // clamp flag tracks the clamp state exactly, no one-cycle lag
    d.c.clamp_active = (d.st == ST_CLAMP);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '{st: ST_IDLE, cf: CFG_RST, cyc: '0, col: '0, row: '0,
             odd_pass: 1'b1, first_frame: 1'b1, v: '0, c: '0};
    end else begin
      q <= d;
    end
  end

  assign vid = q.v;
  assign ctl = q.c;
  assign row_time = trow;
  assign busy = (q.st != ST_IDLE);

  // ==========================================================
  // checks
  // rolling after reset
  rolling_default_a: assert property (@(posedge clk_sys)
    $fell(rst) |-> q.cf.capture_mode == CAP_ROLLING)
    else $error("capture mode not rolling after reset");
  reset_values_a: assert property (@(posedge clk_sys)
    $fell(rst) |-> q.cf.vcol_width == 10'd368 && q.cf.vrow_depth == 10'd499
                   && q.cf.cint == 10'd499)
    else $error("virtual frame reset values wrong");
  row_time_a: assert property (@(posedge clk_sys) disable iff (rst)
    row_time == 24'(q.cf.vcol_width) + 24'(q.cf.shs) + 24'(q.cf.shr) + 24'd19)
    else $error("row time mismatch");
  xfer_order_a: assert property (@(posedge clk_sys) disable iff (rst)
    ctl.global_xfer |=> vid.frame_valid && q.st == ST_ROW)
    else $error("readout did not follow transfer");
  outside_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    q.st == ST_ROW && !(in_win_r && in_win_c) |=> !vid.pixel_valid)
    else $error("pixel outside window");
  field_parity_a: assert property (@(posedge clk_sys) disable iff (rst)
    q.st == ST_ROW && q.cf.scan_mode == SCAN_INTERLACE |->
      q.row[0] == !q.odd_pass)
    else $error("row parity wrong for field");
  prog_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    q.st == ST_ROW && d.st == ST_ROW && q.cf.scan_mode == SCAN_PROG
      && d.row != q.row |=> q.row == $past(q.row) + 10'd1)
    else $error("progressive row skipped");
  // half-rate mono columns drop odd offsets
  sub_half_a: assert property (@(posedge clk_sys) disable iff (rst)
    vid.pixel_valid && q.cf.sub_h == 2'h1 && !q.cf.bayer_space |-> !vid.col[0])
    else $error("half subsample kept odd column");
  clamp_len_a: assert property (@(posedge clk_sys) disable iff (rst)
    q.st == ST_CLAMP && short_row |-> q.cyc < 24'd400)
    else $error("clamp overhead too long");

endmodule

// File: dv/vid_sink.sv
/*
  Downstream video sink model: tallies kept pixels by field parity.
  Assumes the registered video outputs of the readout controller.
*/
`timescale 1ns/1ps
module vid_sink
  import readout_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire vid_t vid,
  output int unsigned pix_odd,
  output int unsigned pix_even,
  output int unsigned stray
);
  // ==========================================================
  // pixel tally
  // a pixel strobe outside a line is counted apart, never as image data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pix_odd <= 0;
      pix_even <= 0;
      stray <= 0;
    end else if (vid.pixel_valid && !(vid.line_valid && vid.frame_valid)) begin
      stray <= stray + 1;
    end else if (vid.pixel_valid && vid.field_odd) begin
      pix_odd <= pix_odd + 1;
    end else if (vid.pixel_valid) begin
      pix_even <= pix_even + 1;
    end
  end
endmodule

// File: dv/image_sensor_readout_timing_tb_top.sv
/*
  Testbench for the readout timing controller: rolling, interlaced,
  subsampled and snapshot frames judged by cycle and pixel counts.
  Assumes the video sink model and inputs driven at the falling edge.
*/
`timescale 1ns/1ps
module image_sensor_readout_timing_tb_top;
  import readout_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  cfg_t cfg = '0;
  logic cfg_load = 1'b1;
  logic snap_start = 1'b0;
  logic [7:0] adc_pixel = 8'h00;
  vid_t vid;
  ctl_t ctl;
  logic [CNT_W-1:0] row_time;
  logic busy;
  int unsigned pix_odd, pix_even, stray, po, pe;
  int err_total = 0;
  int n_tests = 0;
  int hi, lo, x;

  // ==========================================================
  // clock, pixel source and instances
  always #2 clk_sys = ~clk_sys;
  always @(negedge clk_sys) adc_pixel <= adc_pixel + 8'h01;
  readout_timing u_dut (.clk_sys(clk_sys), .rst(rst), .cfg(cfg), .cfg_load(cfg_load),
    .snap_start(snap_start), .adc_pixel(adc_pixel), .vid(vid), .ctl(ctl),
    .row_time(row_time), .busy(busy));
  vid_sink u_sink (.clk_sys(clk_sys), .rst(rst), .vid(vid), .pix_odd(pix_odd),
    .pix_even(pix_even), .stray(stray));

  // ==========================================================
  // checking, waiting and closing
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return ctl.clamp_active;
      1: return vid.frame_valid;
      2: return ctl.global_reset;
      3: return ctl.global_xfer;
      default: return busy;
    endcase
  endfunction
  // bounded wait at falling edges; a hang counts as a mismatch
  task automatic wait_bit(input int s, input logic v, output int n);
    n = 0;
    while (pick(s) !== v) begin
      @(negedge clk_sys);
      n++;
      if (n > 30000) begin
        err_total++;
        finish_test();
      end
    end
  endtask
  // pixel deltas over n fields from the next clamp start
  task automatic run_fields(input int n);
    wait_bit(0, 1'b0, x);
    wait_bit(0, 1'b1, x);
    po = pix_odd;
    pe = pix_even;
    repeat (n) begin
      wait_bit(0, 1'b0, hi);
      wait_bit(0, 1'b1, lo);
    end
    po = pix_odd - po;
    pe = pix_even - pe;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    check(32'(row_time), 32'(ROW_FIXED + VCOL_RST));
    check(32'(busy), 32'h0);
    @(negedge clk_sys);
    rst = 1'b0;
    wait_bit(0, 1'b1, x);
    check(32'(busy), 32'h1);
  endtask
  // short and long rows, the long case 19 periods above the limit
  task automatic t_rolling(input logic [9:0] vc);
    logic [31:0] rt, cl;
    rt = 32'(ROW_FIXED) + 32'(vc) + 32'h3;
    cl = (rt < 32'(CLAMP_LIM)) ? 32'(CLAMP_OVH) : rt;
    cfg.vcol_width = vc;
    run_fields(1);
    run_fields(1);
    check(32'(row_time), rt);
    check(32'(hi), cl);
    check(32'(hi + lo), (rt < 32'(CLAMP_LIM)) ? 32'h6 * rt + cl : 32'h7 * rt);
    check(po + pe, 32'h20);
  endtask
  task automatic t_interlace();
    cfg.scan_mode = SCAN_INTERLACE;
    run_fields(1);
    run_fields(2);
    check(po, 32'h10);
    check(pe, 32'h10);
    cfg.scan_mode = SCAN_PROG;
  endtask
  task automatic t_sub(input logic b, input logic [1:0] h, input logic [1:0] v,
                       input logic [31:0] exp);
    cfg.bayer_space = b;
    cfg.sub_h = h;
    cfg.sub_v = v;
    run_fields(1);
    run_fields(1);
    check(po + pe, exp);
  endtask
  task automatic t_snapshot();
    int n;
    cfg.capture_mode = CAP_SNAPSHOT;
    // software writes the sh timing values as zero
    cfg.shs = 8'h00;
    cfg.shr = 8'h00;
    wait_bit(4, 1'b0, x);
    snap_start = 1'b1;
    @(negedge clk_sys);
    snap_start = 1'b0;
    wait_bit(2, 1'b1, x);
    po = pix_odd + pix_even;
    wait_bit(3, 1'b1, n);
    check(32'(n), 32'(SNAP_STEP) * 32'h3);
    @(negedge clk_sys);
    check(32'(vid.frame_valid), 32'h1);
    wait_bit(4, 1'b0, x);
    check(pix_odd + pix_even - po, 32'h20);
  endtask

  // ==========================================================
  // main sequence: window 4 rows by 8 columns inside a 6-row frame
  initial begin
    cfg.win_row = 10'h001;
    cfg.win_col = 10'h002;
    cfg.win_depth = 10'h004;
    cfg.win_width = 10'h008;
    cfg.vrow_depth = 10'h006;
    cfg.vcol_width = 10'h00e;
    cfg.shs = 8'h01;
    cfg.shr = 8'h02;
    cfg.cint = 10'h002;
    cfg.sint = 24'h000003;
    repeat (20) @(negedge clk_sys);
    t_reset();
    t_rolling(10'h00e);
    t_rolling(10'h18c);
    cfg.vcol_width = 10'h00e;
    t_interlace();
    t_sub(1'b0, 2'h1, 2'h2, 32'h4);
    t_sub(1'b1, 2'h1, 2'h0, 32'h10);
    t_sub(1'b0, 2'h3, 2'h0, 32'h4);
    t_sub(1'b0, 2'h0, 2'h0, 32'h20);
    t_snapshot();
    check(stray, 32'h0);
    finish_test();
  end
endmodule
